/* dv/ilh_ctrl_asserts.sv */
// Port checker for the input-loop lock and holdover control.
// Assumes a bind onto ilh_input_loop_ctrl and a single clock.
`timescale 1ns/1ns
`default_nettype none
module ilh_ctrl_asserts
  import ilh_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 lcm_tick,
  input wire logic                 phase_err_large,
  input wire ilh_pkg::ilh_cfg_t    cfg,
  input wire logic                 reg_wr_en,
  input wire logic [7:0]           reg_addr,
  input wire logic [7:0]           reg_wr_data,
  input wire logic [7:0]           reg_rd_data,
  input wire logic [3:0]           signal_loss_flag,
  input wire ilh_pkg::ilh_status_t status
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic big  = lcm_tick & phase_err_large;
  wire logic good = lcm_tick & ~phase_err_large;
  wire logic may  = cfg.auto_mode | cfg.force_holdover;
  wire logic mapd = reg_addr inside {8'h28, 8'h29, 8'h82};
  chk_rst_clear: assert property ($fell(sys_rst) |-> status == '0)
    else $error("status not reset");
  chk_err_clear: assert property (big |=> !status.lock)
    else $error("lock kept on large error");
  chk_lock_keep: assert property (status.lock && !big |=> status.lock)
    else $error("lock dropped");
  chk_lock_cause: assert property ($rose(status.lock) |-> $past(good))
    else $error("lock without low error tick");
  chk_dac_pump: assert property (status.dac_force |-> status.charge_pump_tristate)
    else $error("dac forced with pump active");
  chk_hold_mode: assert property ($rose(status.charge_pump_tristate) |-> $past(may))
    else $error("manual holdover without force");
  chk_unmapped_zero: assert property (!mapd |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  chk_exp_write:
    assert property (reg_wr_en && reg_addr == 8'h28 ##1 !reg_wr_en && reg_addr == 8'h28
      |=> reg_rd_data == ($past(reg_wr_data, 2) & 8'h1F)) else $error("exponent readback");
  cov_lock: cover property ($rose(status.lock));
  cov_hold: cover property ($rose(status.charge_pump_tristate));
  cov_loss: cover property (signal_loss_flag != 4'h0);
endmodule
bind ilh_input_loop_ctrl ilh_ctrl_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
  .lcm_tick(lcm_tick), .phase_err_large(phase_err_large), .cfg(cfg),
  .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
  .reg_rd_data(reg_rd_data), .signal_loss_flag(signal_loss_flag), .status(status));
`default_nettype wire

/* dv/ilh_ref_src.sv */
// Clock source model: oscillator and four reference paths at the common rate.
// Assumes the bench fails a reference by raising its stop bit.
`timescale 1ns/1ns
`default_nettype none
module ilh_ref_src (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] stop,
  output logic            osc_div,
  output logic      [3:0] ref_div
);
  logic [1:0] ph_r;
  always_ff @(posedge clk) begin
    ph_r <= rst ? 2'h0 : ph_r + 2'h1;
  end
  assign osc_div = ph_r[1];
  // Failed source rests low, so no edge reaches the monitor
  assign ref_div = ph_r[1] ? ~stop : 4'h0;
endmodule
`default_nettype wire

/* dv/test_input_loop_lock_holdover_fsm.sv */
// Self-checking bench for the input-loop lock and holdover control.
// Assumes the clock source model and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
module test_input_loop_lock_holdover_fsm;
  import ilh_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, tick = 1'b1, rnd = 1'b1;
  logic        err = 1'b1, ok = 1'b0, wen = 1'b0, osc;
  logic [7:0]  adr = 8'h00, wd = 8'h00, rdat, tbl, d;
  logic [3:0]  stop = 4'h0, loss, rdiv;
  ilh_cfg_t    cfg = '{1'b1, 1'b0, 4'hF, 8'hE4};
  ilh_status_t st;
  int          bad_count = 0, n_tests = 0, cyc = 0;
  ilh_input_loop_ctrl dut (.clk(clk), .sys_rst(rst), .lcm_tick(tick),
    .phase_err_large(err), .osc_div(osc), .ref_div(rdiv), .cfg(cfg),
    .holdover_exit_ok(ok), .reg_wr_en(wen), .reg_addr(adr), .reg_wr_data(wd),
    .reg_rd_data(rdat), .signal_loss_flag(loss), .status(st));
  ilh_ref_src src (.clk(clk), .rst(rst), .stop(stop), .osc_div(osc), .ref_div(rdiv));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    tick <= rnd ? 1'($urandom) : 1'b1;
    if (cyc == 3000) begin
      bad_count++;
      $display("[ERR] run length expected 3000 seen more");
      tally_and_finish();
    end
  end
  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    wen <= 1'b1;
    adr <= a;
    wd <= v;
    @(posedge clk);
    wen <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
    @(posedge clk);
    adr <= a;
    @(posedge clk);
    #1 chk(nm, rdat, e);
  endtask
  // Polls the state readback every cycle, so one-cycle states are seen
  task automatic wst(logic [2:0] s, string nm);
    @(posedge clk);
    adr <= ILH_OFS_STATE_RB;
    @(posedge clk);
    #1;
    for (int i = 0; i < 60 && rdat[2:0] !== s; i++) begin
      @(posedge clk);
      #1;
    end
    chk(nm, rdat, {5'h00, s});
  endtask
  function automatic logic [1:0] best(logic [7:0] t, logic [3:0] bad);
    best = t[1:0];
    for (int i = 3; i >= 0; i--)
      if (!bad[t[2*i+:2]])
        best = t[2*i+:2];
  endfunction
  initial begin
    void'($urandom(87458));
    d = 8'($urandom % 4);
    tbl = {d[1:0] + 2'h3, d[1:0] + 2'h2, d[1:0] + 2'h1, d[1:0]};
    cfg.priority_table = tbl;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 chk("reset status", 8'(st), 8'h00);
    rd(ILH_OFS_LOCK_CFG, {3'h0, ILH_EXP_RST}, "exponent reset");
    rd(8'h55, 8'h00, "unmapped read");
    wr(ILH_OFS_STATE_RB, 8'hFF);
    rd(ILH_OFS_STATE_RB, 8'h02, "state after preload");
    repeat (3) begin
      d = 8'($urandom);
      wr(ILH_OFS_LOCK_CFG, d);
      rd(ILH_OFS_LOCK_CFG, d & 8'h1F, "exponent field");
    end
    // Short lock period keeps the run brief
    wr(ILH_OFS_LOCK_CFG, 8'h03);
    wr(ILH_OFS_MODE_CTL, 8'h04);
    rd(ILH_OFS_MODE_CTL, 8'h04, "dac bit");
    chk("preload pick", 8'(st.active_ref), 8'(best(tbl, 4'h0)));
    $display("register test done");
    rnd <= 1'b0;
    @(posedge clk);
    err <= 1'b0;
    d = 8'h00;
    while (d < 8'h1E && st.lock !== 1'b1) begin
      @(posedge clk);
      #1 d++;
    end
    chk("ticks to lock", d, 8'h08);
    wst(3'h3, "locked");
    @(posedge clk);
    err <= 1'b1;
    @(posedge clk);
    err <= 1'b0;
    #1 chk("lock cleared", 8'(st.lock), 8'h00);
    wst(3'h4, "lock loss holdover");
    chk("pump tristate", 8'(st.charge_pump_tristate), 8'h01);
    chk("dac force", 8'(st.dac_force), 8'h01);
    @(posedge clk);
    ok <= 1'b1;
    wst(3'h2, "holdover exit");
    @(posedge clk);
    ok <= 1'b0;
    wst(3'h3, "relocked");
    @(posedge clk);
    stop <= 4'h1 << st.active_ref;
    wst(3'h4, "loss holdover");
    chk("loss flag", 8'(loss), 8'(stop));
    @(posedge clk);
    ok <= 1'b1;
    wst(3'h2, "switch in holdover");
    chk("new active", 8'(st.active_ref), 8'(best(tbl, stop)));
    @(posedge clk);
    ok <= 1'b0;
    wst(3'h3, "locked on new ref");
    @(posedge clk);
    stop <= 4'h0;
    wst(3'h4, "priority clash");
    $display("automatic test done");
    @(posedge clk);
    rst <= 1'b1;
    cfg.auto_mode <= 1'b0;
    @(posedge clk);
    rst <= 1'b0;
    #1 chk("reset again", 8'(st), 8'h00);
    wr(ILH_OFS_MODE_CTL, 8'h02);
    repeat (3) @(posedge clk);
    #1 chk("manual select", 8'(st.active_ref), 8'h02);
    @(posedge clk);
    stop <= 4'h4;
    repeat (16) @(posedge clk);
    #1 chk("manual loss", 8'(loss), 8'h04);
    chk("no auto holdover", 8'(st.charge_pump_tristate), 8'h00);
    @(posedge clk);
    cfg.force_holdover <= 1'b1;
    wst(3'h4, "forced holdover");
    // Force off, exit allowed, yet the chosen reference is still lost
    @(posedge clk);
    cfg.force_holdover <= 1'b0;
    ok <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("manual hold on loss", 8'(st.charge_pump_tristate), 8'h01);
    @(posedge clk);
    stop <= 4'h0;
    wst(3'h2, "manual holdover exit");
    $display("manual test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* rtl/ilh_input_loop_ctrl.sv */
// Input-loop lock detect, reference selection and holdover state machine.
// Assumes clk is the system clock, faster than the common rate, and all inputs are synchronous to it.
`timescale 1ns/1ns
`default_nettype none
module ilh_input_loop_ctrl
  import ilh_pkg::*;
#(
  parameter int CNT_W = ILH_CNT_W
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    lcm_tick,
  input  wire logic                    phase_err_large,
  input  wire logic                    osc_div,
  input  wire logic [ILH_NUM_REFS-1:0] ref_div,
  input  wire ilh_pkg::ilh_cfg_t       cfg,
  input  wire logic                    holdover_exit_ok,
  input  wire logic                    reg_wr_en,
  input  wire logic [ILH_ADDR_W-1:0]   reg_addr,
  input  wire logic [ILH_DATA_W-1:0]   reg_wr_data,
  output logic      [ILH_DATA_W-1:0]   reg_rd_data,
  output logic      [ILH_NUM_REFS-1:0] signal_loss_flag,
  output ilh_pkg::ilh_status_t         status
);
  import ilh_pkg::*;

  logic [ILH_EXP_W-1:0]  lock_count_exponent_r;
  logic [ILH_REF_W-1:0]  manual_sel_r;
  logic                  dac_hold_r;
  logic [ILH_DATA_W-1:0] rd_data_r;

  ilh_state_t            state_r;
  ilh_state_t            state_nxt;
  logic [ILH_REF_W-1:0]  active_r;
  logic [ILH_REF_W-1:0]  active_nxt;
  logic                  tristate_r;
  logic                  dac_force_r;

  logic                  lock;
  logic                  best_valid;
  logic [ILH_REF_W-1:0]  best_ref;
  logic                  clash;

  ilh_lock_counter #(
    .CNT_W (CNT_W)
  ) u_lock (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .lcm_tick            (lcm_tick),
    .phase_err_large     (phase_err_large),
    .lock_count_exponent (lock_count_exponent_r),
    .lock                (lock)
  );

  ilh_loss_detect #(
    .NUM_REFS (ILH_NUM_REFS)
  ) u_loss (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .osc_div          (osc_div),
    .ref_div          (ref_div),
    .signal_loss_flag (signal_loss_flag)
  );

  // Register port: byte writes, read data one cycle after the address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_count_exponent_r <= ILH_EXP_RST;
      manual_sel_r          <= ILH_SEL_RST;
      dac_hold_r            <= ILH_DAC_RST;
    end else if (reg_wr_en) begin
      if (reg_addr == ILH_OFS_LOCK_CFG) begin
        lock_count_exponent_r <= reg_wr_data[ILH_EXP_LSB +: ILH_EXP_W];
      end else if (reg_addr == ILH_OFS_MODE_CTL) begin
        manual_sel_r <= reg_wr_data[ILH_SEL_LSB +: ILH_REF_W];
        dac_hold_r   <= reg_wr_data[ILH_DAC_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= '0;
      if (reg_addr == ILH_OFS_LOCK_CFG) begin
        rd_data_r[ILH_EXP_LSB +: ILH_EXP_W] <= lock_count_exponent_r;
      end else if (reg_addr == ILH_OFS_MODE_CTL) begin
        rd_data_r[ILH_SEL_LSB +: ILH_REF_W] <= manual_sel_r;
        rd_data_r[ILH_DAC_BIT]              <= dac_hold_r;
      end else if (reg_addr == ILH_OFS_STATE_RB) begin
        rd_data_r[ILH_STATE_LSB +: ILH_STATE_W] <= state_r;
      end
    end
  end

  assign reg_rd_data = rd_data_r;

  // First usable table entry wins; a repeated entry simply ranks twice
  always_comb begin
    logic [ILH_REF_W-1:0] cand;
    best_valid = 1'b0;
    best_ref   = '0;
    cand       = '0;
    for (int p = ILH_NUM_REFS - 1; p >= 0; p--) begin
      cand = cfg.priority_table[p*ILH_REF_W +: ILH_REF_W];
      if (cfg.ref_enable[cand] && !signal_loss_flag[cand]) begin
        best_valid = 1'b1;
        best_ref   = cand;
      end
    end
  end

  // The best-ranked usable reference differs from the active one
  assign clash = best_valid && (best_ref != active_r);

  always_comb begin
    state_nxt  = state_r;
    active_nxt = active_r;
    case (state_r)
      ILH_INIT: begin
        state_nxt = ILH_PRELOAD;
      end
      ILH_PRELOAD: begin
        if (cfg.auto_mode) begin
          active_nxt = best_valid ? best_ref : active_r;
        end else begin
          active_nxt = manual_sel_r;
        end
        state_nxt = ILH_ACQUIRE;
      end
      ILH_ACQUIRE: begin
        if (!cfg.auto_mode) begin
          active_nxt = manual_sel_r;
          if (cfg.force_holdover) begin
            state_nxt = ILH_HOLDOVER;
          end else if (lock) begin
            state_nxt = ILH_LOCKED;
          end
        end else if (signal_loss_flag[active_r]) begin
          state_nxt = ILH_HOLDOVER;
        end else if (lock) begin
          state_nxt = ILH_LOCKED;
        end
      end
      ILH_LOCKED: begin
        if (!cfg.auto_mode) begin
          active_nxt = manual_sel_r;
          if (cfg.force_holdover) begin
            state_nxt = ILH_HOLDOVER;
          end else if (!lock) begin
            state_nxt = ILH_ACQUIRE;
          end
        end else if (!lock || signal_loss_flag[active_r] || clash) begin
          state_nxt = ILH_HOLDOVER;
        end
      end
      ILH_HOLDOVER: begin
        if (!cfg.auto_mode) begin
          active_nxt = manual_sel_r;
          if (!cfg.force_holdover && !signal_loss_flag[manual_sel_r] && holdover_exit_ok) begin
            state_nxt = ILH_ACQUIRE;
          end
        end else if (best_valid && holdover_exit_ok) begin
          active_nxt = best_ref;
          state_nxt  = ILH_ACQUIRE;
        end
      end
      default: begin
        state_nxt = ILH_INIT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r  <= ILH_INIT;
      active_r <= '0;
    end else begin
      state_r  <= state_nxt;
      active_r <= active_nxt;
    end
  end

  // Pump and DAC (when its bit is set) are registered from the next state, so they change with the state, glitch free
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tristate_r  <= 1'b0;
      dac_force_r <= 1'b0;
    end else begin
      tristate_r  <= (state_nxt == ILH_HOLDOVER);
      dac_force_r <= (state_nxt == ILH_HOLDOVER) && dac_hold_r;
    end
  end

  assign status.lock                 = lock;
  assign status.charge_pump_tristate = tristate_r;
  assign status.dac_force            = dac_force_r;
  assign status.active_ref           = active_r;

endmodule
`default_nettype wire

/* rtl/ilh_lock_counter.sv */
// Lock detector: counts consecutive low-error common-rate cycles.
// Assumes lcm_tick marks each common-rate cycle on the system clock.
`timescale 1ns/1ns
`default_nettype none
module ilh_lock_counter
  import ilh_pkg::*;
#(
  parameter int CNT_W = ILH_CNT_W
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  lcm_tick,
  input  wire logic                  phase_err_large,
  input  wire logic [ILH_EXP_W-1:0]  lock_count_exponent,
  output logic                       lock
);
  import ilh_pkg::*;

  logic [CNT_W-1:0] count_r;
  logic             lock_r;
  logic [CNT_W:0]   limit;
  logic [CNT_W:0]   count_ext;

  assign limit     = {{CNT_W{1'b0}}, 1'b1} << lock_count_exponent;
  assign count_ext = {1'b0, count_r} + {{CNT_W{1'b0}}, 1'b1};
  assign lock      = lock_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_r <= '0;
      lock_r  <= 1'b0;
    end else if (lcm_tick) begin
      if (phase_err_large) begin
        count_r <= '0;
        lock_r  <= 1'b0;
      end else if (!lock_r) begin
        count_r <= count_ext[CNT_W-1:0];
        if (count_ext >= limit) begin
          lock_r <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/ilh_loss_detect.sv */
// Per-reference signal-loss detection against the oscillator path.
// Assumes divided reference and oscillator clocks arrive as synchronous levels.
`timescale 1ns/1ns
`default_nettype none
module ilh_loss_detect
  import ilh_pkg::*;
#(
  parameter int NUM_REFS = ILH_NUM_REFS
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 osc_div,
  input  wire logic [NUM_REFS-1:0]  ref_div,
  output logic      [NUM_REFS-1:0]  signal_loss_flag
);
  import ilh_pkg::*;

  logic                osc_d_r;
  logic [NUM_REFS-1:0] ref_d_r;
  logic                osc_rise;

  assign osc_rise = osc_div & ~osc_d_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_d_r <= 1'b0;
      ref_d_r <= '0;
    end else begin
      osc_d_r <= osc_div;
      ref_d_r <= ref_div;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_REFS; i++) begin : g_ref
      logic [1:0] edges_r;
      logic       flag_r;
      logic       ref_rise;
      assign ref_rise            = ref_div[i] & ~ref_d_r[i];
      assign signal_loss_flag[i] = flag_r;
      // Three edges, not two, so near-equal clocks crossing in phase stay quiet
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          edges_r <= 2'h0;
          flag_r  <= 1'b0;
        end else if (ref_rise) begin
          edges_r <= osc_rise ? 2'h1 : 2'h0;
          flag_r  <= 1'b0;
        end else if (osc_rise) begin
          if (edges_r == 2'(ILH_LOSS_EDGES - 1)) begin
            flag_r <= 1'b1;
          end else begin
            edges_r <= edges_r + 2'h1;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* rtl/ilh_pkg.sv */
// Shared constants and types for the input-loop lock and holdover control.
// Assumes one system clock, faster than the common rate; all inputs synchronous to it.
package ilh_pkg;

  localparam int          ILH_NUM_REFS      = 4;
  localparam int          ILH_REF_W         = 2;
  localparam int          ILH_ADDR_W        = 8;
  localparam int          ILH_DATA_W        = 8;
  localparam int          ILH_EXP_W         = 5;
  localparam int          ILH_STATE_W       = 3;

  localparam logic [7:0]  ILH_OFS_LOCK_CFG  = 8'h28;
  localparam logic [7:0]  ILH_OFS_MODE_CTL  = 8'h29;
  localparam logic [7:0]  ILH_OFS_STATE_RB  = 8'h82;

  localparam int          ILH_EXP_LSB       = 0;
  localparam int          ILH_SEL_LSB       = 0;
  localparam int          ILH_DAC_BIT       = 2;
  localparam int          ILH_STATE_LSB     = 0;

  localparam logic [4:0]  ILH_EXP_RST       = 5'h0F;
  localparam logic [1:0]  ILH_SEL_RST       = 2'h0;
  localparam logic        ILH_DAC_RST       = 1'b0;

  localparam int          ILH_LOSS_EDGES    = 3;
  localparam int          ILH_CNT_W         = 32;

  // Zero-based values of the state readback follow this declaration order
  typedef enum logic [2:0] {
    ILH_INIT,
    ILH_PRELOAD,
    ILH_ACQUIRE,
    ILH_LOCKED,
    ILH_HOLDOVER
  } ilh_state_t;

  typedef struct packed {
    logic       auto_mode;
    logic       force_holdover;
    logic [3:0] ref_enable;
    logic [7:0] priority_table;
  } ilh_cfg_t;

  typedef struct packed {
    logic       lock;
    logic       charge_pump_tristate;
    logic       dac_force;
    logic [1:0] active_ref;
  } ilh_status_t;

endpackage
